// ### core/led_sink_map.svh
// Register offsets, field positions, reset values and timing figures of the sink controller
`ifndef LED_SINK_MAP_SVH
`define LED_SINK_MAP_SVH

// ----------------------------------------------------------------
// Register map (index = printed offset, byte address = 4 * index)
// ----------------------------------------------------------------
`define DRV_INDEX        12'h0AC
`define FC_INDEX         12'h0AD
`define DRV_ADDR         (`DRV_INDEX * 12'h004)
`define FC_ADDR          (`FC_INDEX * 12'h004)
`define FC_RESET         16'h0000
`define DRV_RESET        16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FC_MODE_BIT      15
`define FC_SRC_BIT       14
`define FC_DRIVE_BIT     13
`define FC_RATE_BIT      12
`define FC_DUR_LSB       8
`define FC_OFF_LSB       4
`define FC_ON_LSB        0
`define DRV_ENA_BIT      15
`define DRV_HIB_BIT      12
`define DRV_ISEL_LSB     0

// ----------------------------------------------------------------
// Timing figures as printed, and the clock rate
// ----------------------------------------------------------------
`define CLK_KHZ          125000
`define FLASH_DUR0_MS    32
`define FLASH_DUR1_MS    64
`define FLASH_DUR2_MS    96
`define FLASH_DUR3_MS    1024
`define REPEAT_MS        4000
`define LED_RAMP1_US     250000
`define LED_RAMP2_US     500000
`define LED_RAMP3_US     1000000
`define FL_RAMP1_US      1950
`define FL_RAMP2_US      3910
`define FL_RAMP3_US      7800
`define RAMP_STEPS       256

`endif

// ### core/led_sink_pkg.sv
// Types shared by the sink controller
package led_sink_pkg;

  // ----------------------------------------------------------------
  // Register layouts and flash timer state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sink_function_select;
    logic       flash_trigger_source;
    logic       sink_drive_bit;
    logic       flash_repeat_select;
    logic [1:0] rsv_11_10;
    logic [1:0] flash_length_field;
    logic [1:0] rsv_7_6;
    logic [1:0] switch_off_ramp_field;
    logic [1:0] rsv_3_2;
    logic [1:0] switch_on_ramp_field;
  } flash_ctrl_t;

  typedef struct packed {
    logic       sink_master_enable;
    logic [1:0] rsv_14_13;
    logic       sink_hibernate_behaviour;
    logic [5:0] rsv_11_6;
    logic [5:0] sink_level_select;
  } sink_drv_t;

  typedef enum logic [0:0] {
    FLASH_IDLE,
    FLASH_ON
  } flash_state_t;

endpackage : led_sink_pkg

// ### core/led_flash_sink_controller.sv
// LED / photo-flash current sink controller with APB register access
// Overview of operation
// R01 - Bit 15 of flash control picks steady LED (0) or timed flash (1).
// R02 - Bit 14 picks flash trigger: drive bit (0) or GPIO flash input (1).
// R03 - In LED mode the drive bit switches the sink on or off.
// R04 - Drive bit rising starts a flash; hardware clears it when flash ends.
// R05 - With GPIO trigger selected, drive bit writes do not trigger flashes.
// R06 - Bit 12 selects one flash per trigger or internal retrigger every 4 s.
// R07 - Bits 9:8 set flash length 32, 64, 96 or 1024 ms.
// R08 - LED mode off ramp bits 5:4: none, 0.25 s, 0.5 s, 1 s.
// R09 - Flash mode off ramp: none, 1.95 ms, 3.91 ms, 7.8 ms.
// R10 - On ramp bits 1:0 use the same encoding as the off ramp.
// R11 - Normal repetition gives exactly one flash per trigger from either source.
// R12 - Driver bit 15 master enable gates the sink; no current without it.
// R13 - Driver bit 12: sink off in hibernate (0) or as active (1).
// R14 - Nonzero ramps step current monotonically; instant setting jumps in one step.
// R15 - Power state machine reset returns all flash control fields to zero.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "led_sink_map.svh"

module led_flash_sink_controller #(
  parameter int ADDR_W      = 12,
  parameter int FLASH0_CYC  = `FLASH_DUR0_MS * `CLK_KHZ,
  // Longer lengths follow the shortest by whole-number ratios,
  // so shrinking FLASH0_CYC shrinks all four in proportion
  parameter int FLASH1_CYC  = FLASH0_CYC * (`FLASH_DUR1_MS / `FLASH_DUR0_MS),
  parameter int FLASH2_CYC  = FLASH0_CYC * (`FLASH_DUR2_MS / `FLASH_DUR0_MS),
  parameter int FLASH3_CYC  = FLASH0_CYC * (`FLASH_DUR3_MS / `FLASH_DUR0_MS),
  parameter int REPEAT_CYC  = `REPEAT_MS * `CLK_KHZ,
  parameter int LED_STEP1   = (`LED_RAMP1_US / 1000) * `CLK_KHZ / `RAMP_STEPS,
  parameter int LED_STEP2   = (`LED_RAMP2_US / 1000) * `CLK_KHZ / `RAMP_STEPS,
  parameter int LED_STEP3   = (`LED_RAMP3_US / 1000) * `CLK_KHZ / `RAMP_STEPS,
  parameter int FL_STEP1    = `FL_RAMP1_US * (`CLK_KHZ / 1000) / `RAMP_STEPS,
  parameter int FL_STEP2    = `FL_RAMP2_US * (`CLK_KHZ / 1000) / `RAMP_STEPS,
  parameter int FL_STEP3    = `FL_RAMP3_US * (`CLK_KHZ / 1000) / `RAMP_STEPS
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System
  input  wire logic              pm_reset,
  input  wire logic              hibernate,
  input  wire logic              gpio_flash_in,
  // Sink
  output logic      [5:0]        sink_a_pin_level,
  output logic                   sink_a_pin_on
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    led_sink_pkg::flash_ctrl_t  fc;
    led_sink_pkg::sink_drv_t    drv;
    led_sink_pkg::flash_state_t fstate;
    logic [31:0]                flash_cnt;
    logic [31:0]                rep_cnt;
    logic [31:0]                step_cnt;
    logic [8:0]                 frac;
    logic                       gpio_prev;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [5:0]                 level;
    logic                       on;
  } state_t;

  state_t st_reg;
  state_t st_next;

  localparam logic [8:0] FRAC_FULL = 9'h100;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Cycle count of each flash length code
  function automatic logic [31:0] flash_len(input logic [1:0] code);
    case (code)
      2'h0:    flash_len = 32'(FLASH0_CYC);
      2'h1:    flash_len = 32'(FLASH1_CYC);
      2'h2:    flash_len = 32'(FLASH2_CYC);
      default: flash_len = 32'(FLASH3_CYC);
    endcase
  endfunction : flash_len

  // Zero means instant; otherwise cycles per one of the ramp steps
  function automatic logic [31:0] ramp_step(input logic mode, input logic [1:0] code);
    case ({mode, code})
      3'h1:    ramp_step = 32'(LED_STEP1);
      3'h2:    ramp_step = 32'(LED_STEP2);
      3'h3:    ramp_step = 32'(LED_STEP3);
      3'h5:    ramp_step = 32'(FL_STEP1);
      3'h6:    ramp_step = 32'(FL_STEP2);
      3'h7:    ramp_step = 32'(FL_STEP3);
      default: ramp_step = 32'h0000_0000;
    endcase
  endfunction : ramp_step

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic                      wr_acc;
  logic                      rd_setup;
  logic                      hit_fc;
  logic                      hit_drv;
  logic                      trig;
  logic                      drive_rise;
  logic                      gpio_rise;
  logic                      rep_fire;
  logic                      want_on;
  logic                      gated_off;
  logic [31:0]               step_len;
  logic [14:0]               scaled;
  led_sink_pkg::flash_ctrl_t fc_wr;

  always_comb
  begin
    st_next    = st_reg;
    hit_fc     = (paddr == ADDR_W'(`FC_ADDR));
    hit_drv    = (paddr == ADDR_W'(`DRV_ADDR));
    rd_setup   = psel & ~penable;
    wr_acc     = psel & penable & pwrite & st_reg.pready;
    fc_wr      = led_sink_pkg::flash_ctrl_t'(pwdata[15:0]);
    drive_rise = 1'b0;
    gpio_rise  = 1'b0;
    rep_fire   = 1'b0;
    trig       = 1'b0;
    want_on    = 1'b0;
    gated_off  = 1'b0;
    step_len   = 32'h0000_0000;
    scaled     = 15'h0000;

    // ------------------------------------------------------------
    // APB: setup cycle prepares a one-cycle access phase
    // ------------------------------------------------------------
    st_next.pready  = rd_setup;
    st_next.pslverr = rd_setup & ~(hit_fc | hit_drv);
    // Read data stands only in the access cycle of a read, zero otherwise
    st_next.prdata  = 32'h0000_0000;
    if (rd_setup && !pwrite)
    begin
      if (hit_fc)
        st_next.prdata = {16'h0000, st_reg.fc};
      else if (hit_drv)
        st_next.prdata = {16'h0000, st_reg.drv};
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Reserved bits are dropped on write and read back as zero
    if (wr_acc && hit_fc)
    begin
      st_next.fc = fc_wr;
      st_next.fc.rsv_11_10 = 2'h0;
      st_next.fc.rsv_7_6   = 2'h0;
      st_next.fc.rsv_3_2   = 2'h0;
      drive_rise = fc_wr.sink_drive_bit & ~st_reg.fc.sink_drive_bit; // [R04]
    end
    if (wr_acc && hit_drv)
    begin
      st_next.drv = led_sink_pkg::sink_drv_t'(pwdata[15:0]);
      st_next.drv.rsv_14_13 = 2'h0;
      st_next.drv.rsv_11_6  = 6'h00;
    end

    // ------------------------------------------------------------
    // Trigger selection, only meaningful in flash mode
    // ------------------------------------------------------------
    // Previous-cycle compare; the pin is already synchronous to pclk
    gpio_rise         = gpio_flash_in & ~st_reg.gpio_prev;
    st_next.gpio_prev = gpio_flash_in;
    // Repeat period counts from entering flash mode with repeat on
    if (st_reg.fc.sink_function_select && st_reg.fc.flash_repeat_select) // [R06]
    begin
      if (st_reg.rep_cnt >= 32'(REPEAT_CYC - 1))
      begin
        st_next.rep_cnt = 32'h0000_0000;
        rep_fire = 1'b1;
      end
      else
        st_next.rep_cnt = st_reg.rep_cnt + 32'h0000_0001;
    end
    else
      st_next.rep_cnt = 32'h0000_0000;

    // Settings in force before this cycle decide, so set flash mode before raising drive
    if (st_reg.fc.sink_function_select) // [R01]
    begin
      if (st_reg.fc.flash_trigger_source) // [R02]
        trig = gpio_rise; // [R05]
      else
        trig = drive_rise;
      trig = trig | rep_fire;
    end

    // ------------------------------------------------------------
    // Flash timer; a trigger during a flash is ignored, one flash per trigger
    // ------------------------------------------------------------
    case (st_reg.fstate)
      led_sink_pkg::FLASH_IDLE:
      begin
        if (trig) // [R11]
        begin
          st_next.fstate    = led_sink_pkg::FLASH_ON;
          // Loaded with one less, so the active state lasts exactly the length
          st_next.flash_cnt = flash_len(st_reg.fc.flash_length_field) - 32'h0000_0001; // [R07]
        end
      end
      led_sink_pkg::FLASH_ON:
      begin
        if (!st_reg.fc.sink_function_select)
          st_next.fstate = led_sink_pkg::FLASH_IDLE;
        else if (st_reg.flash_cnt == 32'h0000_0000)
        begin
          st_next.fstate = led_sink_pkg::FLASH_IDLE;
          // Self-clear loses to a write of one landing in the same cycle
          if (!(wr_acc && hit_fc && fc_wr.sink_drive_bit) &&
              !st_reg.fc.flash_trigger_source)
            st_next.fc.sink_drive_bit = 1'b0; // [R04]
        end
        else
          st_next.flash_cnt = st_reg.flash_cnt - 32'h0000_0001;
      end
      default: st_next.fstate = led_sink_pkg::FLASH_IDLE;
    endcase

    // ------------------------------------------------------------
    // Sink request and gating
    // ------------------------------------------------------------
    if (st_reg.fc.sink_function_select)
      want_on = (st_reg.fstate == led_sink_pkg::FLASH_ON);
    else
      want_on = st_reg.fc.sink_drive_bit; // [R03]
    gated_off = ~st_reg.drv.sink_master_enable |
                (hibernate & ~st_reg.drv.sink_hibernate_behaviour); // [R12] [R13]

    // ------------------------------------------------------------
    // Ramp: one unit of frac per step period, toward full or zero
    // ------------------------------------------------------------
    if (want_on)
      step_len = ramp_step(st_reg.fc.sink_function_select,
                           st_reg.fc.switch_on_ramp_field); // [R10]
    else
      step_len = ramp_step(st_reg.fc.sink_function_select,
                           st_reg.fc.switch_off_ramp_field); // [R08] [R09]

    if (gated_off)
    begin
      // Disabling cuts current at once; a ramp would leak current past the gate
      st_next.frac     = 9'h000;
      st_next.step_cnt = 32'h0000_0000;
    end
    else if ((want_on && st_reg.frac == FRAC_FULL) || (!want_on && st_reg.frac == 9'h000))
      st_next.step_cnt = 32'h0000_0000;
    else if (step_len == 32'h0000_0000)
    begin
      st_next.frac     = want_on ? FRAC_FULL : 9'h000; // [R14]
      st_next.step_cnt = 32'h0000_0000;
    end
    else if (st_reg.step_cnt >= step_len - 32'h0000_0001)
    begin
      st_next.step_cnt = 32'h0000_0000;
      st_next.frac     = want_on ? st_reg.frac + 9'h001 : st_reg.frac - 9'h001; // [R14]
    end
    else
      st_next.step_cnt = st_reg.step_cnt + 32'h0000_0001;

    // ------------------------------------------------------------
    // Output level: programmed code scaled by the ramp fraction
    // ------------------------------------------------------------
    scaled = 15'(st_reg.drv.sink_level_select) * 15'(st_reg.frac);
    // A gated sink shows no stale code in the cycle its on flag drops
    if (gated_off)
      st_next.level = 6'h00;
    else if (st_reg.frac == FRAC_FULL)
      st_next.level = st_reg.drv.sink_level_select;
    else
      st_next.level = scaled[13:8];
    st_next.on = ~gated_off & (st_reg.frac != 9'h000);

    // ------------------------------------------------------------
    // Power state machine reset clears both registers and all sequencing
    // ------------------------------------------------------------
    if (pm_reset)
    begin
      st_next.fc        = led_sink_pkg::flash_ctrl_t'(`FC_RESET); // [R15]
      st_next.drv       = led_sink_pkg::sink_drv_t'(`DRV_RESET);
      st_next.fstate    = led_sink_pkg::FLASH_IDLE;
      st_next.flash_cnt = 32'h0000_0000;
      st_next.rep_cnt   = 32'h0000_0000;
      st_next.step_cnt  = 32'h0000_0000;
      st_next.frac      = 9'h000;
      st_next.level     = 6'h00;
      st_next.on        = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Whole state registered together, so every output comes straight from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg.fc        <= led_sink_pkg::flash_ctrl_t'(`FC_RESET); // [R15]
      st_reg.drv       <= led_sink_pkg::sink_drv_t'(`DRV_RESET);
      st_reg.fstate    <= led_sink_pkg::FLASH_IDLE;
      st_reg.flash_cnt <= 32'h0000_0000;
      st_reg.rep_cnt   <= 32'h0000_0000;
      st_reg.step_cnt  <= 32'h0000_0000;
      st_reg.frac      <= 9'h000;
      st_reg.gpio_prev <= 1'b0;
      st_reg.prdata    <= 32'h0000_0000;
      st_reg.pready    <= 1'b0;
      st_reg.pslverr   <= 1'b0;
      st_reg.level     <= 6'h00;
      st_reg.on        <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata           = st_reg.prdata;
  assign pready           = st_reg.pready;
  assign pslverr          = st_reg.pslverr;
  assign sink_a_pin_level = st_reg.level;
  assign sink_a_pin_on    = st_reg.on;

endmodule : led_flash_sink_controller

// ### tb/led_sink_checker.sv
// Port-level assertions for the sink controller
`timescale 1ns/1ps
`include "led_sink_map.svh"

module led_sink_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // System and sink
  input wire logic              pm_reset,
  input wire logic              hibernate,
  input wire logic [5:0]        sink_a_pin_level,
  input wire logic              sink_a_pin_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = (paddr == ADDR_W'(`DRV_ADDR)) || (paddr == ADDR_W'(`FC_ADDR));

  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  answer_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  err_unmapped_a: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag outside access");
  rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  rdata_upper_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  pm_clear_a: assert property (pm_reset |-> ##2 !sink_a_pin_on)
    else $error("sink on after state machine reset");
  dark_zero_a: assert property (!sink_a_pin_on |-> sink_a_pin_level == 6'h00)
    else $error("level while sink off");

  cover property ($rose(sink_a_pin_on));
  cover property (pslverr);
  cover property (hibernate && sink_a_pin_on);
endmodule : led_sink_checker

bind led_flash_sink_controller led_sink_checker #(.ADDR_W(ADDR_W)) led_sink_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pm_reset(pm_reset), .hibernate(hibernate), .sink_a_pin_level(sink_a_pin_level),
  .sink_a_pin_on(sink_a_pin_on));

// ### tb/led_string_model.sv
// LED string on the sink pin: counts flashes and their length
`timescale 1ns/1ps

module led_string_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Sink pin
  input  wire logic [5:0] level,
  input  wire logic       on,
  // Observations
  output int              flashes,
  output int              last_len,
  output logic            lit
);
  int run;
  // Light needs both the switch and a nonzero current
  assign lit = on && (level != 6'h00);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flashes <= 0;
      last_len <= 0;
      run <= 0;
    end
    else
    begin
      run <= lit ? run + 1 : 0;
      if (lit && run == 0)
        flashes <= flashes + 1;
      if (!lit && run != 0)
        last_len <= run;
    end
  end
endmodule : led_string_model

// ### tb/led_flash_sink_controller_test.sv
// Self-checking bench for the sink controller
`timescale 1ns/1ps
`include "led_sink_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module led_flash_sink_controller_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, on, lit;
  logic        pm_reset, hibernate, gpio_flash_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  level, prev;
  int          num_errors, n_tests, flashes, last_len, f0, drops;
  int          cyc[4] = '{32, 64, 96, 1024};

  led_flash_sink_controller #(.FLASH0_CYC(32), .REPEAT_CYC(1500), .LED_STEP1(1),
    .LED_STEP3(3), .FL_STEP1(1)) led_flash_sink_controller_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_reset(pm_reset), .hibernate(hibernate), .gpio_flash_in(gpio_flash_in),
    .sink_a_pin_level(level), .sink_a_pin_on(on));
  led_string_model led_string_model_inst (.clk(pclk), .rst_n(presetn), .level(level),
    .on(on), .flashes(flashes), .last_len(last_len), .lit(lit));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_sim();
    end
  endtask : apb

  // Bounded wait for the light to reach a state
  task automatic wait_lit(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && lit !== v; n++)
      @(posedge pclk);
    if (lit !== v)
    begin
      num_errors++;
      end_sim();
    end
  endtask : wait_lit

  task automatic t_regs;
    apb(0, `FC_ADDR, 16'h0000);
    `CHK("fc reset", 32'h0, rd)
    apb(1, `FC_ADDR, 16'h3333);
    apb(0, `FC_ADDR, 16'h0000);
    `CHK("fc rw", 32'h3333, rd)
    apb(1, 12'h004, 16'hFFFF);
    `CHK("unmapped err", 1'b1, err)
    pm_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    pm_reset <= 1'b0;
    apb(0, `FC_ADDR, 16'h0000);
    `CHK("fc pm clear", 32'h0, rd)
  endtask : t_regs

  task automatic t_led;
    apb(1, `DRV_ADDR, 16'h802A);
    apb(1, `FC_ADDR, 16'h2000);
    repeat (4) @(posedge pclk);
    `CHK("led level", 6'h2A, level)
    hibernate <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("hib off", 1'b0, on)
    apb(1, `DRV_ADDR, 16'h902A);
    repeat (3) @(posedge pclk);
    `CHK("hib keep", 1'b1, on)
    hibernate <= 1'b0;
    apb(1, `DRV_ADDR, 16'h102A);
    repeat (3) @(posedge pclk);
    `CHK("master off", 1'b0, on)
    apb(1, `DRV_ADDR, 16'h802A);
    apb(1, `FC_ADDR, 16'h0000);
    repeat (3) @(posedge pclk);
    `CHK("drive off", 1'b0, on)
  endtask : t_led

  task automatic t_ramp;
    drops = 0;
    prev = 6'h00;
    apb(1, `FC_ADDR, 16'h2031);
    repeat (20) @(posedge pclk);
    `CHK("ramp partial", 1'b1, level < 6'h2A)
    repeat (300)
    begin
      @(posedge pclk);
      if (level < prev)
        drops++;
      prev = level;
    end
    `CHK("ramp drops", 0, drops)
    `CHK("ramp top", 6'h2A, level)
    apb(1, `FC_ADDR, 16'h0031);
    repeat (100) @(posedge pclk);
    `CHK("off ramp on", 1'b1, on)
    wait_lit(1'b0, 1000);
  endtask : t_ramp

  task automatic t_flash_reg;
    for (int d = 0; d < 4; d++)
    begin
      f0 = flashes;
      // Flash mode first; the drive edge only counts once the mode is in force
      apb(1, `FC_ADDR, 16'h8000 | (16'(d) << 8));
      apb(1, `FC_ADDR, 16'hA000 | (16'(d) << 8));
      wait_lit(1'b1, 20);
      wait_lit(1'b0, 1100);
      repeat (50) @(posedge pclk);
      `CHK("flash len", cyc[d], last_len)
      `CHK("one flash", f0 + 1, flashes)
      apb(0, `FC_ADDR, 16'h0000);
      `CHK("drive clear", 32'h8000 | (32'(d) << 8), rd)
    end
  endtask : t_flash_reg

  task automatic t_flash_gpio;
    f0 = flashes;
    // Longest flash with short flash-mode ramps on both edges
    apb(1, `FC_ADDR, 16'hC311);
    apb(1, `FC_ADDR, 16'hE311);
    repeat (100) @(posedge pclk);
    `CHK("drive ignored", f0, flashes)
    gpio_flash_in <= 1'b1;
    repeat (3) @(posedge pclk);
    gpio_flash_in <= 1'b0;
    wait_lit(1'b1, 20);
    `CHK("flash on ramp", 1'b1, level < 6'h2A)
    wait_lit(1'b0, 1400);
    repeat (50) @(posedge pclk);
    `CHK("gpio flash", f0 + 1, flashes)
    `CHK("flash off ramp", 1'b1, last_len > 1100)
  endtask : t_flash_gpio

  task automatic t_repeat;
    apb(1, `FC_ADDR, 16'h9000);
    f0 = flashes;
    repeat (3100) @(posedge pclk);
    `CHK("repeat flashes", f0 + 2, flashes)
    apb(1, `FC_ADDR, 16'h0000);
  endtask : t_repeat

  initial
  begin
    {presetn, psel, penable, pwrite, pm_reset, hibernate, gpio_flash_in} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_led();
    t_ramp();
    t_flash_reg();
    t_flash_gpio();
    t_repeat();
    end_sim();
  end
endmodule : led_flash_sink_controller_test
